// ---- include/sdr_params.svh ----
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH

// ****************************************************************
// Timing figures
// ****************************************************************
// System clock rate in hertz.
`define SDR_CLK_FREQ_HZ 25000000
// PWM oscillator rate in hertz.
`define SDR_OSC_FREQ_HZ 50000
// Tachometer one-shot on time in microseconds.
`define SDR_TACH_ON_TIME_US 220
// Cycles of one PWM oscillator period.
`define SDR_OSC_PERIOD_CYCLES (`SDR_CLK_FREQ_HZ / `SDR_OSC_FREQ_HZ)
// Cycles of the tachometer on time.
`define SDR_TACH_ON_CYCLES (`SDR_TACH_ON_TIME_US * (`SDR_CLK_FREQ_HZ / 1000000))

// ****************************************************************
// Phase one-hot codes for the drive outputs
// ****************************************************************
`define SDR_PHASE_NONE 3'h0
`define SDR_PHASE_A 3'h1
`define SDR_PHASE_B 3'h2
`define SDR_PHASE_C 3'h4

// ****************************************************************
// Rotor position codes, six valid sensor states
// ****************************************************************
`define SDR_POS_1 3'h1
`define SDR_POS_3 3'h3
`define SDR_POS_2 3'h2
`define SDR_POS_6 3'h6
`define SDR_POS_4 3'h4
`define SDR_POS_5 3'h5
// Code held by the synchronisers during reset; never a real sensor state.
`define SDR_POS_NONE 3'h0

`endif

// ---- include/sdr_pkg.sv ----
// ****************************************************************
// Shared types
// ****************************************************************
package sdr_pkg;

    // Tachometer one-shot states, Gray coded along idle to high.
    typedef enum logic [1:0] {
        SDR_TACH_IDLE = 2'h0,
        SDR_TACH_HIGH = 2'h1
    } sdr_tach_state_t;

endpackage : sdr_pkg

// ---- logic/sdr_commutation_decoder.sv ----
`timescale 1ns/1ps
`include "sdr_params.svh"

// ****************************************************************
// Commutation decoder
// ****************************************************************
// Pure table from rotor position and direction to one high-side and
// one low-side phase. Reverse simply swaps the two phases, which keeps
// the table small and symmetric.
module sdr_commutation_decoder (
    input  wire logic [2:0] rotor_position,
    input  wire logic       direction,
    output logic      [2:0] high_phase,
    output logic      [2:0] low_phase
);

    logic [2:0] fwd_high;  // Forward high-side phase.
    logic [2:0] fwd_low;   // Forward low-side phase.

    // Forward table; invalid codes 000 and 111 drive nothing.
    always_comb begin
        case (rotor_position)
            `SDR_POS_1: begin
                fwd_high = `SDR_PHASE_A;
                fwd_low  = `SDR_PHASE_B;
            end
            `SDR_POS_3: begin
                fwd_high = `SDR_PHASE_A;
                fwd_low  = `SDR_PHASE_C;
            end
            `SDR_POS_2: begin
                fwd_high = `SDR_PHASE_B;
                fwd_low  = `SDR_PHASE_C;
            end
            `SDR_POS_6: begin
                fwd_high = `SDR_PHASE_B;
                fwd_low  = `SDR_PHASE_A;
            end
            `SDR_POS_4: begin
                fwd_high = `SDR_PHASE_C;
                fwd_low  = `SDR_PHASE_A;
            end
            `SDR_POS_5: begin
                fwd_high = `SDR_PHASE_C;
                fwd_low  = `SDR_PHASE_B;
            end
            default: begin
                fwd_high = `SDR_PHASE_NONE;
                fwd_low  = `SDR_PHASE_NONE;
            end
        endcase
    end

    // Reverse direction swaps high and low sides.
    always_comb begin
        high_phase = direction ? fwd_low : fwd_high;
        low_phase  = direction ? fwd_high : fwd_low;
    end

endmodule : sdr_commutation_decoder

// ---- logic/sdr_direction_core.sv ----
`timescale 1ns/1ps
`include "sdr_params.svh"

// Contract
// - Decode position and direction into drive commands.
// - Direction request passes a latch first.
// - Two-stage shift register; last stage steers decoder.
// - Latch transparent while speed below threshold.
// - Latch holds while speed above threshold.
// - Latch or register mismatch forces drives off.
// - Register advances only on oscillator ticks.
// - Direction changes spaced one to two periods.
// - Direction toggle emits a tachometer pulse.
// - Comparator weighs error level against PWM input.
// - Comparator trip clears latch, chopping outputs.
module sdr_direction_core #(
    parameter int LEVEL_W           = 8,
    parameter int OSC_PERIOD_CYCLES = `SDR_OSC_PERIOD_CYCLES,
    parameter int TACH_ON_CYCLES    = `SDR_TACH_ON_CYCLES
) (
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               dir_request,
    input  wire logic               speed_above_threshold,
    input  wire logic [2:0]         rotor_position_inputs,
    input  wire logic [LEVEL_W-1:0] error_amp_level,
    input  wire logic [LEVEL_W-1:0] pwm_in_level,
    output logic      [2:0]         high_side_drive,
    output logic      [2:0]         low_side_drive,
    output logic                    tach_pulse_out,
    output logic [$clog2(OSC_PERIOD_CYCLES)-1:0] oscillator_timing_node
);

    // ****************************************************************
    // Local widths and constants
    // ****************************************************************
    localparam int OSC_W  = $clog2(OSC_PERIOD_CYCLES);
    localparam int TACH_W = $clog2(TACH_ON_CYCLES + 1);
    localparam int SYNC_W = 5 + 2 * LEVEL_W;
    localparam logic [OSC_W-1:0]  OSC_LAST  = OSC_W'(OSC_PERIOD_CYCLES - 1);
    localparam logic [TACH_W-1:0] TACH_LOAD = TACH_W'(TACH_ON_CYCLES - 1);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    logic [SYNC_W-1:0]  sync_meta;  // First stage, read only by sync_out.
    logic [SYNC_W-1:0]  sync_out;   // Second stage, safe for logic.
    logic               dir_sync;   // Requested direction.
    logic               speed_sync; // Speed comparator result.
    logic [2:0]         pos_sync;   // Rotor position.
    logic [LEVEL_W-1:0] err_sync;   // Error amplifier level.
    logic [LEVEL_W-1:0] ramp_sync;  // PWM input level.

    // All pins pass two flops. The level words may tear for one cycle
    // while they change; the comparator tolerates a one-cycle glitch.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync_meta <= '0;
            sync_out  <= '0;
        end else begin
            sync_meta <= {dir_request, speed_above_threshold,
                          rotor_position_inputs, error_amp_level, pwm_in_level};
            sync_out  <= sync_meta;
        end
    end

    // Unpack the synchronised bundle.
    always_comb begin
        dir_sync   = sync_out[SYNC_W-1];
        speed_sync = sync_out[SYNC_W-2];
        pos_sync   = sync_out[SYNC_W-3 -: 3];
        err_sync   = sync_out[2*LEVEL_W-1 -: LEVEL_W];
        ramp_sync  = sync_out[LEVEL_W-1:0];
    end

    // ****************************************************************
    // PWM oscillator
    // ****************************************************************
    logic [OSC_W-1:0] osc_count; // Position within the period.
    logic             osc_tick;  // One-cycle pulse at period start.

    // Free-running period counter; the tick marks each new period.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            osc_count <= '0;
            osc_tick  <= 1'b0;
        end else begin
            osc_count <= (osc_count == OSC_LAST) ? '0 : osc_count + 1'b1;
            osc_tick  <= (osc_count == OSC_LAST);
        end
    end

    // The ramp is exported so a voltage-mode loop can feed it back.
    always_comb begin
        oscillator_timing_node = osc_count;
    end

    // ****************************************************************
    // Direction latch and shift register
    // ****************************************************************
    logic       dir_latch; // Speed-gated direction latch.
    logic [1:0] dir_stage; // Two-stage shift register.
    logic       inhibit;   // Mismatch across latch or register.

    // Latch follows the request only while the motor is slow, so a
    // fast motor with high stored energy cannot be reversed.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dir_latch <= 1'b0;
        end else if (!speed_sync) begin
            dir_latch <= dir_sync;
        end
        // Above threshold the latch holds its value.
    end

    // Register moves only on oscillator ticks; a change crosses two
    // stages, which gives one to two periods of dead time.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dir_stage <= 2'h0;
        end else if (osc_tick) begin
            dir_stage <= {dir_stage[0], dir_latch};
        end
    end

    // Any disagreement blanks the drives until both ends settle.
    always_comb begin
        inhibit = (dir_sync != dir_latch) || (dir_latch != dir_stage[1]);
    end

    // ****************************************************************
    // PWM comparator and latch
    // ****************************************************************
    logic pwm_trip;  // Ramp has reached the error level.
    logic pwm_latch; // Drives enabled for this period.

    // On-time ends once the PWM input reaches the error level.
    always_comb begin
        pwm_trip = (ramp_sync >= err_sync);
    end

    // A trip in the tick cycle keeps the latch clear: chopping is the
    // safe side when both arrive together.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pwm_latch <= 1'b0;
        end else if (pwm_trip) begin
            pwm_latch <= 1'b0;
        end else if (osc_tick) begin
            pwm_latch <= 1'b1;
        end
    end

    // ****************************************************************
    // Commutation and drive outputs
    // ****************************************************************
    logic [2:0] dec_high;     // Decoded high-side phase.
    logic [2:0] dec_low;      // Decoded low-side phase.
    logic       drive_enable; // Latch set and no inhibit.

    sdr_commutation_decoder u_decoder (
        .rotor_position (pos_sync),
        .direction      (dir_stage[1]),
        .high_phase     (dec_high),
        .low_phase      (dec_low)
    );

    always_comb begin
        drive_enable = pwm_latch && !inhibit;
    end

    // Outputs are registered so the power stage never sees decode glitches.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            high_side_drive <= 3'h0;
            low_side_drive  <= 3'h0;
        end else if (drive_enable) begin
            high_side_drive <= dec_high;
            low_side_drive  <= dec_low;
        end else begin
            high_side_drive <= 3'h0;
            low_side_drive  <= 3'h0;
        end
    end

    // ****************************************************************
    // Tachometer one-shot
    // ****************************************************************
    logic                     dir_prev;   // Last direction request.
    logic [2:0]               pos_prev;   // Last rotor position.
    logic                     tach_trig;  // Toggle or sensor edge.
    sdr_pkg::sdr_tach_state_t tach_state; // One-shot state.
    logic [TACH_W-1:0]        tach_count; // Remaining on cycles.

    // Sensors change one bit per step, so any difference is one edge.
    always_comb begin
        tach_trig = (dir_sync != dir_prev)
                    || ((pos_sync != pos_prev) && (pos_prev != `SDR_POS_NONE));
    end

    // History for edge detection.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            dir_prev <= 1'b0;
            pos_prev <= 3'h0;
        end else begin
            dir_prev <= dir_sync;
            pos_prev <= pos_sync;
        end
    end

    // Retriggerable one-shot; a new edge restarts the on time.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tach_state <= sdr_pkg::SDR_TACH_IDLE;
            tach_count <= '0;
        end else if (tach_trig) begin
            tach_state <= sdr_pkg::SDR_TACH_HIGH;
            tach_count <= TACH_LOAD;
        end else begin
            case (tach_state)
                sdr_pkg::SDR_TACH_IDLE: begin
                    tach_count <= '0;
                end
                sdr_pkg::SDR_TACH_HIGH: begin
                    if (tach_count == '0) begin
                        tach_state <= sdr_pkg::SDR_TACH_IDLE;
                    end else begin
                        tach_count <= tach_count - 1'b1;
                    end
                end
                default: begin
                    tach_state <= sdr_pkg::SDR_TACH_IDLE;
                end
            endcase
        end
    end

    // Pulse output from its own flop.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            tach_pulse_out <= 1'b0;
        end else begin
            tach_pulse_out <= tach_trig || ((tach_state == sdr_pkg::SDR_TACH_HIGH)
                              && (tach_count != '0));
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [15:0] since_change; // Cycles since last effective change.

    // Helper counter, saturating, only read by an assertion.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            since_change <= 16'hFFFF;
        end else if (dir_stage[1] != dir_stage[0] && osc_tick) begin
            since_change <= 16'h0000;
        end else if (since_change != 16'hFFFF) begin
            since_change <= since_change + 16'h0001;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    property p_decode;
        $past(drive_enable) |-> (high_side_drive == $past(dec_high))
            && (low_side_drive == $past(dec_low));
    endproperty
    a_decode: assert property (p_decode) else $error("drive not decoded");

    property p_stage_from_latch;
        $changed(dir_stage[0]) |-> dir_stage[0] == $past(dir_latch);
    endproperty
    a_stage_from_latch: assert property (p_stage_from_latch)
        else $error("stage one not from latch");

    property p_last_stage;
        $changed(dir_stage[1]) |-> dir_stage[1] == $past(dir_stage[0]);
    endproperty
    a_last_stage: assert property (p_last_stage)
        else $error("last stage not shifted");

    property p_transparent;
        !speed_sync |=> dir_latch == $past(dir_sync);
    endproperty
    a_transparent: assert property (p_transparent)
        else $error("latch not transparent");

    property p_hold;
        speed_sync |=> $stable(dir_latch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved at speed");

    property p_inhibit;
        inhibit |=> (high_side_drive == 3'h0) && (low_side_drive == 3'h0);
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("drive during mismatch");

    property p_tick_only;
        $changed(dir_stage) |-> $past(osc_tick);
    endproperty
    a_tick_only: assert property (p_tick_only) else $error("shift without tick");

    property p_spacing;
        $changed(dir_stage[1]) |-> $past(since_change) >= 16'(OSC_PERIOD_CYCLES - 1);
    endproperty
    a_spacing: assert property (p_spacing) else $error("direction changes too close");

    property p_tach;
        $changed(dir_sync) |=> tach_pulse_out;
    endproperty
    a_tach: assert property (p_tach) else $error("no tach pulse on toggle");

    property p_trip;
        (ramp_sync >= err_sync) |=> !pwm_latch;
    endproperty
    a_trip: assert property (p_trip) else $error("trip left latch set");

    property p_chop;
        !pwm_latch |=> (high_side_drive == 3'h0) && (low_side_drive == 3'h0);
    endproperty
    a_chop: assert property (p_chop) else $error("drive while chopped");

    property p_set;
        osc_tick && !pwm_trip |=> pwm_latch;
    endproperty
    a_set: assert property (p_set) else $error("latch not set at period");

    property p_gate;
        (high_side_drive != 3'h0) |-> $past(pwm_latch) && !$past(inhibit);
    endproperty
    a_gate: assert property (p_gate) else $error("drive without enable");

endmodule : sdr_direction_core

// ---- verif/sdr_rotor_model.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Rotor sensor model
// ****************************************************************
// Three hall sensors sit 120 degrees apart. Each step request moves
// the rotor one sixth of a turn, so exactly one sensor flips per move.
module sdr_rotor_model (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       step,
    output logic      [2:0] rotor_position
);
    logic [2:0] sixth; // Sixth of a turn the rotor sits in.

    // Advance one sixth per request; reset parks the rotor at sixth 0.
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sixth <= 3'h0;
        end else if (step) begin
            sixth <= (sixth == 3'h5) ? 3'h0 : sixth + 3'h1;
        end
    end

    // Sensor pattern per sixth; neighbours differ in one bit only.
    always_comb begin
        case (sixth)
            3'h0: rotor_position = 3'h1;
            3'h1: rotor_position = 3'h3;
            3'h2: rotor_position = 3'h2;
            3'h3: rotor_position = 3'h6;
            3'h4: rotor_position = 3'h4;
            default: rotor_position = 3'h5;
        endcase
    end
endmodule : sdr_rotor_model

// ---- verif/tb.sv ----
`timescale 1ns/1ps

// ****************************************************************
// Direction core testbench
// ****************************************************************
module tb;
    localparam int OSC  = 8; // Short oscillator period keeps the run brief.
    localparam int TACH = 4; // Short tachometer pulse.

    // One table row: sensor code, direction, expected phases.
    typedef struct packed {
        logic [2:0] pos;
        logic       dir;
        logic [2:0] high;
        logic [2:0] low;
    } sdr_row_t;

    logic       clk;              // System clock.
    logic       resetn;           // Synchronous reset, active low.
    logic       dir_q;            // Requested direction.
    logic       speed;            // Speed comparator result.
    logic       step;             // Rotor step request to the model.
    logic       chop;             // When set, the PWM input follows the ramp.
    logic [2:0] pos;              // Sensor code from the model.
    logic [7:0] err;              // Error amplifier level.
    logic [7:0] pwm_fixed;        // Fixed PWM input level.
    logic [7:0] pwm_in = 8'h00;   // Level presented to the design.
    logic [2:0] high;             // High-side phase command.
    logic [2:0] low;              // Low-side phase command.
    logic       tach;             // Tachometer pulse.
    logic [2:0] osc_node;         // Oscillator ramp.
    int         bad_count;        // Mismatches seen.
    int         checked;          // Comparisons made.
    int         tach_count;       // Tachometer pulses seen.
    int         on;               // Cycles with drives on while chopping.
    int         wrong;            // Cycles with a wrong phase while chopping.

    // Forward first, then reverse, walking the rotor one sixth per row.
    sdr_row_t rows [12] = '{
        '{3'h1, 1'b0, 3'h1, 3'h2}, '{3'h3, 1'b0, 3'h1, 3'h4},
        '{3'h2, 1'b0, 3'h2, 3'h4}, '{3'h6, 1'b0, 3'h2, 3'h1},
        '{3'h4, 1'b0, 3'h4, 3'h1}, '{3'h5, 1'b0, 3'h4, 3'h2},
        '{3'h1, 1'b1, 3'h2, 3'h1}, '{3'h3, 1'b1, 3'h4, 3'h1},
        '{3'h2, 1'b1, 3'h4, 3'h2}, '{3'h6, 1'b1, 3'h1, 3'h2},
        '{3'h4, 1'b1, 3'h1, 3'h4}, '{3'h5, 1'b1, 3'h2, 3'h4}
    };

    sdr_direction_core #(
        .LEVEL_W           (8),
        .OSC_PERIOD_CYCLES (OSC),
        .TACH_ON_CYCLES    (TACH)
    ) DUT (
        .clk                    (clk),
        .resetn                 (resetn),
        .dir_request            (dir_q),
        .speed_above_threshold  (speed),
        .rotor_position_inputs  (pos),
        .error_amp_level        (err),
        .pwm_in_level           (pwm_in),
        .high_side_drive        (high),
        .low_side_drive         (low),
        .tach_pulse_out         (tach),
        .oscillator_timing_node (osc_node)
    );

    sdr_rotor_model u_rotor (
        .clk            (clk),
        .resetn         (resetn),
        .step           (step),
        .rotor_position (pos)
    );

    // ****************************************************************
    // Clock, PWM input and pulse counting
    // ****************************************************************
    // The clock runs at 25 MHz.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // One driver for the PWM input; chopping ties it to the ramp.
    always @(posedge clk) begin
        pwm_in <= chop ? {5'h00, osc_node} : pwm_fixed;
    end

    // Rising tachometer edges are counted, since pulses may be short.
    always @(posedge tach) begin
        tach_count++;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check3(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check3

    task automatic check1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check1

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    // Drives are sampled mid-cycle, well clear of the edge.
    task automatic check_drives(input logic [2:0] eh, input logic [2:0] el);
        @(negedge clk);
        check3(high, eh);
        check3(low, el);
    endtask : check_drives

    // Reverse with speed low and time the blanking gap of the drives.
    task automatic reverse_timed(input logic nd, input logic [2:0] eh, input logic [2:0] el);
        int off;
        int t0;
        off = 0;
        t0 = tach_count;
        @(posedge clk) dir_q <= nd;
        for (int k = 0; k < 60; k++) begin
            @(negedge clk);
            if (high === 3'h0 && low === 3'h0) begin
                off++;
            end else if (off > 0) begin
                break;
            end
        end
        check1(off >= OSC && off <= 2 * OSC + 2, 1'b1);
        check3(high, eh);
        check3(low, el);
        check1(tach_count == t0 + 1, 1'b1);
    endtask : reverse_timed

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        resetn = 1'b0;
        dir_q = 1'b0;
        speed = 1'b0;
        step = 1'b0;
        chop = 1'b0;
        err = 8'hFF;
        pwm_fixed = 8'h00;
        bad_count = 0;
        checked = 0;
        tach_count = 0;
        wait_cyc(2);
        @(posedge clk) resetn <= 1'b1;
        wait_cyc(2 * OSC);
        // Table walk; the comparator never trips with these levels.
        foreach (rows[i]) begin
            if (dir_q !== rows[i].dir) @(posedge clk) dir_q <= rows[i].dir;
            if (i > 0) begin
                @(posedge clk) step <= 1'b1;
                @(posedge clk) step <= 1'b0;
            end
            wait_cyc(4 * OSC);
            check3(pos, rows[i].pos);
            check_drives(rows[i].high, rows[i].low);
        end
        // Back-to-back reversals at the last position.
        reverse_timed(1'b0, 3'h4, 3'h2);
        reverse_timed(1'b1, 3'h2, 3'h4);
        // A request made at speed is held off and blanks the drives.
        tach_count = 0;
        @(posedge clk) speed <= 1'b1;
        wait_cyc(4);
        @(posedge clk) dir_q <= 1'b0;
        wait_cyc(4 * OSC);
        check_drives(3'h0, 3'h0);
        check1(tach_count == 1, 1'b1);
        @(posedge clk) speed <= 1'b0;
        wait_cyc(4 * OSC);
        check_drives(3'h4, 3'h2);
        // A comparator trip chops; the next period start restores.
        @(posedge clk) begin
            err <= 8'h80;
            pwm_fixed <= 8'h90;
        end
        wait_cyc(6);
        check_drives(3'h0, 3'h0);
        @(posedge clk) pwm_fixed <= 8'h00;
        wait_cyc(2 * OSC + 4);
        check_drives(3'h4, 3'h2);
        // Ramp-driven chopping. The ramp reaches the comparator three
        // cycles late, so at the period start it still shows step five;
        // a level of seven trips only on the top step, giving two drive
        // cycles in each period.
        @(posedge clk) begin
            err <= 8'h07;
            chop <= 1'b1;
        end
        wait_cyc(2 * OSC);
        on = 0;
        wrong = 0;
        repeat (4 * OSC) begin
            @(negedge clk);
            if (high !== 3'h0 || low !== 3'h0) begin
                on++;
                if (high !== 3'h4 || low !== 3'h2) wrong++;
            end
        end
        check1(on == 4 * 2, 1'b1);
        check1(wrong == 0, 1'b1);
        // A second reset in mid-run silences every output.
        @(posedge clk) begin
            chop <= 1'b0;
            resetn <= 1'b0;
        end
        wait_cyc(3);
        check_drives(3'h0, 3'h0);
        check1(tach, 1'b0);
        check3(osc_node, 3'h0);
        @(posedge clk) resetn <= 1'b1;
        wait_cyc(4);
        summarize();
    end
endmodule : tb
